// ---- dv/core_model.sv ----
// processor core model issuing one virtual address access at a time
`timescale 1ns/1ps
`default_nettype none
module core_model
(
  input  wire logic                  clk_sys,
  output var  tlb_pkg::lookup_req_t  lookupReq,
  input  wire tlb_pkg::lookup_resp_t lookupResp
);
  import tlb_pkg::*;
  initial lookupReq = '0;
  // request holds for one edge; released lines carry the inverse so stale values never pass
  task automatic access(input logic [31:0] va, input logic w, input logic priv, output lookup_resp_t r);
    lookupReq <= '{valid: 1'b1, vaddr: va, write: w, privileged: priv};
    @(posedge clk_sys);
    lookupReq <= '{valid: 1'b0, vaddr: ~va, write: ~w, privileged: ~priv};
    repeat (LOOKUP_LAT) @(posedge clk_sys);
    r = lookupResp;
  endtask
endmodule
`default_nettype wire

// ---- dv/tlb_lookup_and_page_check_properties.sv ----
// port-level assertion checker for the translation buffer
`timescale 1ns/1ps
`default_nettype none
module tlb_lookup_and_page_check_properties
(
  input wire logic                          clk_sys,
  input wire logic                          rst_n,
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic [tlb_pkg::ADDR_W-1:0]    paddr,
  input wire logic [31:0]                   pwdata,
  input wire logic [31:0]                   prdata,
  input wire logic                          pready,
  input wire logic                          pslverr,
  input wire tlb_pkg::lookup_req_t          lookupReq,
  input wire tlb_pkg::lookup_resp_t         lookupResp
);
  import tlb_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // ------------------------------------------------------------
  // shadow of software state, seen only through completed writes
  // ------------------------------------------------------------
  logic        mapEn;
  logic        anyLoad;
  logic [31:0] lastVa;
  logic        next_mapEn;
  logic        next_anyLoad;
  logic        wrDone;
  // an entry load makes later misses unpredictable, a flush makes them certain again
  always_comb
  begin
    wrDone = psel && penable && pready && pwrite;
    next_mapEn = mapEn;
    next_anyLoad = anyLoad;
    if (wrDone && paddr == OFS_CONTROL)
    begin
      next_mapEn = pwdata[CTL_ENABLE_BIT];
      if (pwdata[CTL_FLUSH_BIT])
        next_anyLoad = 1'b0;
    end
    if (wrDone && paddr == OFS_LOADCMD)
      next_anyLoad = 1'b1;
  end
  always_ff @(posedge clk_sys)
  begin
    lastVa <= lookupReq.vaddr;
    if (!rst_n)
    begin
      mapEn <= 1'b0;
      anyLoad <= 1'b0;
    end
    else
    begin
      mapEn <= next_mapEn;
      anyLoad <= next_anyLoad;
    end
  end

  // ------------------------------------------------------------
  // lookup outcome properties and register bus ready timing
  // ------------------------------------------------------------
  sequence s_ok;
    lookupResp.valid && lookupResp.translated && lookupResp.fault == FAULT_NONE;
  endsequence
  sequence s_fixed(logic [2:0] win);
    lookupReq.valid && mapEn && lookupReq.vaddr[31:29] == win;
  endsequence
  property p_answer;
    lookupReq.valid |=> lookupResp.valid;
  endproperty
  a_answer: assert property (p_answer) else $error("lookup answer missing");
  property p_quiet;
    !lookupReq.valid |=> lookupResp == '0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("spurious lookup answer");
  property p_bypass;
    lookupReq.valid && !mapEn |=> s_ok ##0 lookupResp.physAddr == lastVa;
  endproperty
  a_bypass: assert property (p_bypass) else $error("unmapped access altered");
  property p_fixCached;
    s_fixed(REGION_FIX_A) |=> s_ok ##0 (lookupResp.cacheable && lookupResp.physAddr == {3'h0, lastVa[28:0]});
  endproperty
  a_fixCached: assert property (p_fixCached) else $error("cached window wrong");
  property p_fixUncached;
    s_fixed(REGION_FIX_B) |=> s_ok ##0 (!lookupResp.cacheable && lookupResp.physAddr == {3'h0, lastVa[28:0]});
  endproperty
  a_fixUncached: assert property (p_fixUncached) else $error("uncached window wrong");
  property p_faultClean;
    lookupResp.valid && lookupResp.fault != FAULT_NONE |-> !lookupResp.translated && lookupResp.physAddr == '0;
  endproperty
  a_faultClean: assert property (p_faultClean) else $error("fault with address");
  property p_emptyMiss;
    lookupReq.valid && mapEn && !anyLoad && lookupReq.vaddr[31:30] != 2'b10 |=> lookupResp.fault == FAULT_MISS;
  endproperty
  a_emptyMiss: assert property (p_emptyMiss) else $error("hit in empty buffer");
  property p_readyTime;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_readyTime: assert property (p_readyTime) else $error("bus answer timing wrong");
endmodule

bind tlb_lookup_and_page_check tlb_lookup_and_page_check_properties chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .lookupReq(lookupReq), .lookupResp(lookupResp));
`default_nettype wire

// ---- dv/tlb_lookup_and_page_check_tb_top.sv ----
// self-checking bench for the translation buffer
`timescale 1ns/1ps
`default_nettype none
module tlb_lookup_and_page_check_tb_top;
  import tlb_pkg::*;
  localparam logic [18:0] PA = 19'h5_A5A5;
  localparam logic [18:0] PB = 19'h1_2345;
  logic         clk_sys = 1'b0;
  logic         rst_n   = 1'b0;
  logic         psel    = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite  = 1'b0;
  logic [7:0]   paddr   = 8'h00;
  logic [31:0]  pwdata  = 32'h0000_0000;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  lookup_req_t  lookupReq;
  lookup_resp_t lookupResp;
  lookup_resp_t rsp;
  logic [31:0]  rd;
  logic         err;
  logic         ok;
  fault_t       f;
  int           errorCnt = 0;
  int           nTests   = 0;

  initial
  begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  tlb_lookup_and_page_check DUT (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lookupReq(lookupReq), .lookupResp(lookupResp));
  core_model core (.clk_sys(clk_sys), .lookupReq(lookupReq), .lookupResp(lookupResp));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic giveVerdict();
    $display("comparisons %0d mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp)
    begin
      $display("FAIL %s expected %h seen %h", nm, exp, got);
      errorCnt++;
    end
  endtask
  // one bus transfer; the idle cycle after it keeps strobes from being driven twice at one edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1)
    begin
      errorCnt++;
      giveVerdict();
    end
    else
    begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0000_0000);
    chk("prdata", exp, rd);
    chk("pslverr", e, err);
  endtask
  function automatic logic [31:0] ent(input logic [18:0] p, input logic [1:0] r, input logic big, c, d, cmn);
    return {3'h0, p, 1'b0, 1'b1, 1'b0, r, big, c, d, cmn, 1'b0};
  endfunction
  task automatic load(input logic [1:0] way, input logic [31:0] va, input logic [7:0] t, input logic [31:0] lo);
    wr(OFS_STAGING, {va[31:10], 2'b00, t});
    wr(OFS_ENTRYLO, lo);
    wr(OFS_LOADCMD, {30'h0000_0000, way});
  endtask
  task automatic look(input logic [31:0] va, input logic w, input logic priv, input fault_t fe, input logic [31:0] pa);
    core.access(va, w, priv, rsp);
    chk("valid", 1'b1, rsp.valid);
    chk("translated", fe == FAULT_NONE, rsp.translated);
    chk("fault", fe, rsp.fault);
    chk("physAddr", pa, rsp.physAddr);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rdc(OFS_CONTROL, 32'h0000_0000, 1'b0);
    rdc(OFS_STATUS, 32'h0000_0000, 1'b0);
    rdc(8'h40, 32'h0000_0000, 1'b1);
    look(32'h8123_4567, 1'b1, 1'b0, FAULT_NONE, 32'h8123_4567);
    wr(OFS_CONTROL, 32'h0000_0001);
    look(32'h8123_4567, 1'b1, 1'b1, FAULT_NONE, 32'h0123_4567);
    chk("cacheable", 1'b1, rsp.cacheable);
    look(32'hA123_4567, 1'b0, 1'b1, FAULT_NONE, 32'h0123_4567);
    chk("cacheable", 1'b0, rsp.cacheable);
    look(32'h0001_3400, 1'b0, 1'b1, FAULT_MISS, 32'h0000_0000);
    // every rights code against privileged/user and read/write, on a never-written 4k page
    for (int r = 0; r < 4; r++)
    begin
      load(2'h0, 32'h0001_3400, 8'h25, ent(PA, r[1:0], 1'b1, r[1], 1'b0, 1'b0));
      for (int m = 0; m < 4; m++)
      begin
        ok = m[0] ? (!m[1] || r[0]) : (r[1] && (!m[1] || r[0]));
        f = !ok ? FAULT_PROTECT : (m[1] ? FAULT_FIRST_WRITE : FAULT_NONE);
        look(32'h0001_3B21, m[1], m[0], f, f == FAULT_NONE ? {3'h0, PA[18:2], 12'hB21} : 32'h0000_0000);
        if (f == FAULT_NONE)
          chk("cacheable", r[1], rsp.cacheable);
      end
    end
    // 1k page in the last way: low page bits now count
    load(2'h3, 32'h0002_5400, 8'h25, ent(PB, 2'h3, 1'b0, 1'b1, 1'b1, 1'b0));
    // staged page number and tag, and the staged entry word, read back as written
    rdc(OFS_STAGING, 32'h0002_5425, 1'b0);
    rdc(OFS_ENTRYLO, ent(PB, 2'h3, 1'b0, 1'b1, 1'b1, 1'b0), 1'b0);
    look(32'h0002_5804, 1'b1, 1'b0, FAULT_MISS, 32'h0000_0000);
    look(32'h0002_5404, 1'b1, 1'b0, FAULT_NONE, {3'h0, PB, 10'h004});
    rdc(OFS_STATUS, 32'h0000_0130, 1'b0);
    // process tag compare, and its privileged bypass in single space mode
    wr(OFS_STAGING, 32'h0000_0026);
    look(32'h0001_3400, 1'b0, 1'b1, FAULT_MISS, 32'h0000_0000);
    wr(OFS_CONTROL, 32'h0000_0101);
    look(32'h0001_3400, 1'b0, 1'b1, FAULT_NONE, {3'h0, PA[18:2], 12'h400});
    look(32'h0001_3400, 1'b0, 1'b0, FAULT_MISS, 32'h0000_0000);
    wr(OFS_CONTROL, 32'h0000_0001);
    // shared entries sit in distinct sets so no lookup can hit twice; none maps control space
    load(2'h1, 32'h0003_6000, 8'h27, ent(PB, 2'h3, 1'b1, 1'b0, 1'b1, 1'b1));
    wr(OFS_STAGING, 32'h0000_0031);
    look(32'h0003_6010, 1'b0, 1'b0, FAULT_NONE, {3'h0, PB[18:2], 12'h010});
    chk("cacheable", 1'b0, rsp.cacheable);
    wr(OFS_CONTROL, 32'h0000_0003);
    look(32'h0003_6010, 1'b0, 1'b0, FAULT_MISS, 32'h0000_0000);
    load(2'h2, 32'h0003_6000, 8'h31, ent(PA, 2'h3, 1'b1, 1'b1, 1'b1, 1'b1));
    look(32'h0003_6010, 1'b0, 1'b0, FAULT_NONE, {3'h0, PA[18:2], 12'h010});
    wr(OFS_CONTROL, 32'h0000_0001);
    look(32'h0003_6010, 1'b0, 1'b0, FAULT_NONE, {3'h0, PB[18:2], 12'h010});
    // flush drops every present flag
    wr(OFS_CONTROL, 32'h0000_0005);
    look(32'h0003_6010, 1'b0, 1'b0, FAULT_MISS, 32'h0000_0000);
    giveVerdict();
  end
endmodule
`default_nettype wire

// ---- hdl/tlb_lookup_and_page_check.sv ----
// translation buffer: entry storage, set indexing, parallel compare and page checks
//
// What this block does
// - four ways of 32 entries, 128 page translations with control bits.
// - hash select 0 indexes by virtual page number bits 16..12.
// - hash select 1 xors those bits with staged tag bits 4..0.
// - index never depends on an entry's page size.
// - all four ways compared at once against page number and staged tag.
// - a way hits only if everything matches and present is 1.
// - page number bits 11..10 compared only for 1 kbyte pages.
// - tag compared only for entries not common to all processes.
// - single space mode in privileged state skips every tag compare.
// - write to unwritten page raises initial page write in both states.
// - line-store bit of the hit entry decides cached or uncached access.
// - rights 00 privileged read only, 01 privileged read/write, user faults.
// - rights 10 read only for both states, 11 full access.
// - no hitting way gives a translation miss.
// - two fixed kernel windows bypass the buffer with hardware mapping.
// - mapping disabled passes the virtual address through unchanged.
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module tlb_lookup_and_page_check
(
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [tlb_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  input  wire tlb_pkg::lookup_req_t  lookupReq,
  output var  tlb_pkg::lookup_resp_t lookupResp
);
  import tlb_pkg::*;

  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------

  // set index; page size deliberately plays no part
  function automatic logic [4:0] setIndex(input logic [4:0] vpnLow, input logic [4:0] tagLow,
                                          input logic hash);
    setIndex = hash ? (vpnLow ^ tagLow) : vpnLow;
  endfunction

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    isMapped = (a == OFS_CONTROL) || (a == OFS_STAGING) || (a == OFS_ENTRYLO) ||
               (a == OFS_LOADCMD) || (a == OFS_STATUS);
  endfunction

  // access rights table, true when the access is permitted
  function automatic logic rightsOk(input logic [1:0] r, input logic wr, input logic priv);
    unique case (r)
      RIGHTS_PRIV_RO: rightsOk = priv && !wr;
      RIGHTS_PRIV_RW: rightsOk = priv;
      RIGHTS_ALL_RO:  rightsOk = !wr;
      RIGHTS_ALL_RW:  rightsOk = 1'b1;
    endcase
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  entry_t       entries [ENTRIES];   // index is {way, set}
  entry_t       next_entries [ENTRIES];
  control_t     ctrl;
  control_t     next_ctrl;
  staging_t     staging;
  staging_t     next_staging;
  logic [31:0]  entryLo;
  logic [31:0]  next_entryLo;
  logic [31:0]  next_prdata;
  logic         next_pready;
  logic         next_pslverr;
  lookup_resp_t next_lookupResp;
  fault_t       lastFault;
  fault_t       next_lastFault;
  logic [1:0]   lastWay;
  logic [1:0]   next_lastWay;
  logic         lastHit;
  logic         next_lastHit;

  logic         apbWrite;
  logic         apbSetup;
  logic [6:0]   loadSlot;

  // a write lands only at the completing access edge
  assign apbWrite = psel && penable && pready && pwrite;
  assign apbSetup = psel && !penable;
  assign loadSlot = {pwdata[1:0], setIndex(staging.virtual_page_number[6:2], staging.tag[4:0], ctrl.hash)};

  // ------------------------------------------------------------
  // register bus: no wait state, answers registered in the setup cycle so all come from flops
  // ------------------------------------------------------------
  always_comb
  begin
    next_pready  = apbSetup;
    next_pslverr = apbSetup && !isMapped(paddr);
    next_prdata  = ERROR_WORD;
    if (apbSetup && !pwrite)
    begin
      unique case (paddr)
        OFS_CONTROL:
        begin
          next_prdata = RESET_WORD;
          next_prdata[CTL_ENABLE_BIT] = ctrl.enable;
          next_prdata[CTL_HASH_BIT]   = ctrl.hash;
          next_prdata[CTL_SINGLE_BIT] = ctrl.single; // flush bit always reads zero
        end
        OFS_STAGING: next_prdata = {staging.virtual_page_number, 2'b00, staging.tag};
        OFS_ENTRYLO: next_prdata = entryLo;
        OFS_STATUS:
        begin
          next_prdata = RESET_WORD;
          next_prdata[1:0] = lastFault;
          next_prdata[ST_WAY_LSB +: 2] = lastWay;
          next_prdata[ST_HIT_BIT] = lastHit;
        end
        default: next_prdata = ERROR_WORD;     // load command and holes read zero
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      prdata  <= RESET_WORD;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ------------------------------------------------------------
  // configuration registers and entry storage
  // ------------------------------------------------------------

  // flush and load sit at different offsets and never share a write cycle, so a load
  // and flush in separate writes behave as software expects
  always_comb
  begin
    next_ctrl    = ctrl;
    next_staging = staging;
    next_entryLo = entryLo;
    for (int i = 0; i < ENTRIES; i++)
    begin
      next_entries[i] = entries[i];
    end
    if (apbWrite)
    begin
      unique case (paddr)
        OFS_CONTROL:
        begin
          next_ctrl.enable = pwdata[CTL_ENABLE_BIT];
          next_ctrl.hash   = pwdata[CTL_HASH_BIT];
          next_ctrl.single = pwdata[CTL_SINGLE_BIT];
          if (pwdata[CTL_FLUSH_BIT])
          begin
            for (int i = 0; i < ENTRIES; i++)
            begin
              next_entries[i].present = 1'b0;
            end
          end
        end
        OFS_STAGING:
        begin
          next_staging.virtual_page_number = pwdata[31:HI_VPN_LSB];
          next_staging.tag = pwdata[7:0];
        end
        OFS_ENTRYLO: next_entryLo = pwdata;
        OFS_LOADCMD:
        begin
          // loads use the same index as lookups so a loaded entry is findable
          next_entries[loadSlot].virtual_page_number       = staging.virtual_page_number;
          next_entries[loadSlot].tag       = staging.tag;
          next_entries[loadSlot].ppn       = entryLo[28:LO_PPN_LSB];
          next_entries[loadSlot].present   = entryLo[LO_PRESENT_BIT];
          next_entries[loadSlot].pageSize  = entryLo[LO_SIZE_BIT];
          next_entries[loadSlot].shared    = entryLo[LO_SHARED_BIT];
          next_entries[loadSlot].rights    = entryLo[LO_RIGHTS_LSB +: 2];
          next_entries[loadSlot].cacheable = entryLo[LO_CACHE_BIT];
          next_entries[loadSlot].written   = entryLo[LO_WRITTEN_BIT];
        end
        default: next_ctrl = ctrl;              // status is read only
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ctrl    <= '0;
      staging <= '0;
      entryLo <= RESET_WORD;
      for (int i = 0; i < ENTRIES; i++)
      begin
        entries[i] <= '0;
      end
    end
    else
    begin
      ctrl    <= next_ctrl;
      staging <= next_staging;
      entryLo <= next_entryLo;
      for (int i = 0; i < ENTRIES; i++)
      begin
        entries[i] <= next_entries[i];
      end
    end
  end

  // ------------------------------------------------------------
  // lookup: compare, check, answer one cycle after the request
  // ------------------------------------------------------------

  // with several ways hitting the lowest is taken; software keeps that from happening
  always_comb
  begin
    logic [4:0] set;
    logic       anyHit;
    logic [1:0] hitWay;
    logic       skipTag;
    entry_t     e;
    entry_t     hitEntry;
    set      = setIndex(lookupReq.vaddr[16:12], staging.tag[4:0], ctrl.hash);
    anyHit   = 1'b0;
    hitWay   = 2'd0;
    hitEntry = '0;
    e        = '0;
    skipTag  = ctrl.single && lookupReq.privileged;
    for (int w = WAYS - 1; w >= 0; w--)
    begin
      e = entries[{2'(w), set}];
      if (e.present
          && e.virtual_page_number[21:2] == lookupReq.vaddr[31:12]
          && (e.pageSize || e.virtual_page_number[1:0] == lookupReq.vaddr[11:10])
          && (e.shared || skipTag || e.tag == staging.tag))
      begin
        anyHit   = 1'b1;
        hitWay   = 2'(w);
        hitEntry = e;
      end
    end

    next_lookupResp            = '0;
    next_lookupResp.valid      = lookupReq.valid;
    next_lookupResp.fault      = FAULT_NONE;
    next_lastFault             = lastFault;
    next_lastWay               = lastWay;
    next_lastHit               = lastHit;
    if (!ctrl.enable)
    begin
      next_lookupResp.translated = 1'b1;
      next_lookupResp.physAddr   = lookupReq.vaddr;
      next_lookupResp.cacheable  = 1'b1;
    end
    else if (lookupReq.vaddr[31:29] == REGION_FIX_A || lookupReq.vaddr[31:29] == REGION_FIX_B)
    begin
      next_lookupResp.translated = 1'b1;
      next_lookupResp.physAddr   = {3'b000, lookupReq.vaddr[28:0]};
      next_lookupResp.cacheable  = lookupReq.vaddr[31:29] == REGION_FIX_A;
    end
    else if (!anyHit)
    begin
      next_lookupResp.fault = FAULT_MISS;
    end
    else if (!rightsOk(hitEntry.rights, lookupReq.write, lookupReq.privileged))
    begin
      next_lookupResp.fault = FAULT_PROTECT;
    end
    else if (lookupReq.write && !hitEntry.written)
    begin
      next_lookupResp.fault = FAULT_FIRST_WRITE;
    end
    else
    begin
      next_lookupResp.translated = 1'b1;
      next_lookupResp.cacheable  = hitEntry.cacheable;
      next_lookupResp.physAddr   = hitEntry.pageSize
        ? {3'b000, hitEntry.ppn[18:2], lookupReq.vaddr[11:0]}
        : {3'b000, hitEntry.ppn, lookupReq.vaddr[9:0]};
    end

    // status keeps the outcome of the most recent mapped lookup
    if (lookupReq.valid && ctrl.enable)
    begin
      next_lastFault = next_lookupResp.fault;
      next_lastWay   = hitWay;
      next_lastHit   = anyHit;
    end
    if (!lookupReq.valid)
    begin
      next_lookupResp = '0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      lookupResp <= '0;
      lastFault  <= FAULT_NONE;
      lastWay    <= 2'd0;
      lastHit    <= 1'b0;
    end
    else
    begin
      lookupResp <= next_lookupResp;
      lastFault  <= next_lastFault;
      lastWay    <= next_lastWay;
      lastHit    <= next_lastHit;
    end
  end

endmodule

`default_nettype wire

// ---- hdl/tlb_pkg.sv ----
// shared constants, field layouts and carrier types for the translation buffer
package tlb_pkg;

  // ------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------
  localparam int WAYS       = 4;
  localparam int SETS       = 32;
  localparam int ENTRIES    = 128;
  localparam int ADDR_W     = 8;
  localparam int LOOKUP_LAT = 1;   // cycles from request to answer

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STAGING = 8'h04;
  localparam logic [7:0] OFS_ENTRYLO = 8'h08;
  localparam logic [7:0] OFS_LOADCMD = 8'h0C;
  localparam logic [7:0] OFS_STATUS  = 8'h10;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTL_ENABLE_BIT = 0;
  localparam int CTL_HASH_BIT   = 1;
  localparam int CTL_FLUSH_BIT  = 2;
  localparam int CTL_SINGLE_BIT = 8;
  localparam int LO_WRITTEN_BIT = 2;
  localparam int LO_CACHE_BIT   = 3;
  localparam int LO_SHARED_BIT  = 1;
  localparam int LO_SIZE_BIT    = 4;
  localparam int LO_RIGHTS_LSB  = 5;
  localparam int LO_PRESENT_BIT = 8;
  localparam int LO_PPN_LSB     = 10;
  localparam int HI_VPN_LSB     = 10;
  localparam int ST_WAY_LSB     = 4;
  localparam int ST_HIT_BIT     = 8;

  // ------------------------------------------------------------
  // reset values and fixed codes
  // ------------------------------------------------------------
  localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
  localparam logic [31:0] ERROR_WORD   = 32'h0000_0000;
  localparam logic [2:0]  REGION_FIX_A = 3'h4;  // cached kernel window
  localparam logic [2:0]  REGION_FIX_B = 3'h5;  // uncached kernel window
  localparam logic [1:0]  RIGHTS_PRIV_RO = 2'h0;
  localparam logic [1:0]  RIGHTS_PRIV_RW = 2'h1;
  localparam logic [1:0]  RIGHTS_ALL_RO  = 2'h2;
  localparam logic [1:0]  RIGHTS_ALL_RW  = 2'h3;

  typedef enum logic [1:0] {FAULT_NONE, FAULT_MISS, FAULT_PROTECT, FAULT_FIRST_WRITE} fault_t;

  typedef struct packed {
    logic [21:0] virtual_page_number;          // virtual address bits 31..10
    logic [7:0]  tag;          // process space tag
    logic [18:0] ppn;          // physical address bits 28..10
    logic        present;
    logic        pageSize;     // 0: 1 kbyte, 1: 4 kbyte
    logic        shared;
    logic [1:0]  rights;
    logic        cacheable;
    logic        written;
  } entry_t;

  typedef struct packed {
    logic [21:0] virtual_page_number;
    logic [7:0]  tag;
  } staging_t;

  typedef struct packed {
    logic enable;
    logic hash;
    logic single;
  } control_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] vaddr;
    logic        write;
    logic        privileged;
  } lookup_req_t;

  typedef struct packed {
    logic        valid;
    logic        translated;
    fault_t      fault;
    logic [31:0] physAddr;
    logic        cacheable;
  } lookup_resp_t;

endpackage
